// ---- inc/hti_defs.vh ----
// Overview of operation
// - answer only bus address 0x70, write low
// - acknowledge each received byte after eighth clock
// - command is two bytes, each acknowledged
// - 0x7CA2, 0x5C24 measure with stretching
// - 0x7866, 0x58E0 measure without stretching, order
// - conversion starts at final command acknowledge
// - no-stretch measuring: headers not acknowledged
// - stretch measuring: ack read, hold clock low
// - read after measurement returns six bytes
// - master nack stops sending, release data
// - 0x805D resets state, reloads calibration
// - 0xEFC8 then read returns id and crc
// - id low six bits fixed product code
// - crc8 poly 0x31 init 0xFF no reflection
// - after power-up delay enter idle
// - return to idle when not busy
// - results are the raw 16-bit input words, sent unchanged; no compensation is applied
// - lines only driven low
// - start opens transfer, repeated start accepted
// - soft reset back to idle within 230 us
// - measurement completes within 14.4 ms
`ifndef HTI_DEFS_VH
`define HTI_DEFS_VH
`define HTI_ADDR 7'h70
`define HTI_CMD_MT_S 16'h7CA2
`define HTI_CMD_MH_S 16'h5C24
`define HTI_CMD_MT_N 16'h7866
`define HTI_CMD_MH_N 16'h58E0
`define HTI_CMD_RST 16'h805D
`define HTI_CMD_ID 16'hEFC8
`define HTI_CRC_POLY 8'h31
`define HTI_CRC_INIT 8'hFF
`define HTI_CLK_MHZ 20
`define HTI_TPU_US 239
`define HTI_TSR_US 230
`define HTI_TMEAS_US 14400
`define HTI_PROD_CODE 6'h07
`endif

// ---- hw/hti_sensor.v ----
`timescale 1ns/1ps
`default_nettype none
`include "hti_defs.vh"
module hti_sensor #(
  parameter PU_CYC = `HTI_TPU_US * `HTI_CLK_MHZ,
  parameter SR_CYC = `HTI_TSR_US * `HTI_CLK_MHZ,
  parameter MEAS_CYC = `HTI_TMEAS_US * `HTI_CLK_MHZ,
  parameter [9:0] ID_UPPER = 10'h000
) (
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire [15:0] raw_humidity_word,
  input wire [15:0] raw_temperature_word,
  output wire idle,
  output wire measuring,
  output wire calib_reload
);
  // bus states
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_RX = 3'd1;
  localparam [2:0] S_RXACK = 3'd2;
  localparam [2:0] S_TX = 3'd3;
  localparam [2:0] S_TXACK = 3'd4;
  localparam [2:0] S_STRETCH = 3'd5;
  // core states
  localparam [1:0] C_PU = 2'd0;
  localparam [1:0] C_IDLE = 2'd1;
  localparam [1:0] C_MEAS = 2'd2;
  localparam [1:0] C_DONE = 2'd3;
  localparam integer CW = 20;

  function [7:0] crc_step;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] r;
    begin
      r = c ^ d;
      for (i = 0; i < 8; i = i + 1)
        r = r[7] ? ((r << 1) ^ `HTI_CRC_POLY) : (r << 1);
      crc_step = r;
    end
  endfunction

  function [7:0] crc16;
    input [15:0] w;
    begin
      crc16 = crc_step(crc_step(`HTI_CRC_INIT, w[15:8]), w[7:0]);
    end
  endfunction

  // two-flop synchronisers for pins
  reg [1:0] scl_s_q, sda_s_q;
  reg scl_q, sda_q;
  always @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
    end
  wire scl_r = scl_s_q[1] & ~scl_q;
  wire scl_f = ~scl_s_q[1] & scl_q;
  wire start_c = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
  wire stop_c = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

  reg [2:0] bs_q;
  reg [1:0] cs_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [2:0] bidx_q;
  reg hdr_q, rd_q, mine_q, ack_q, sda_low_q, scl_low_q;
  reg [7:0] cmd_hi_q;
  reg stretch_q, hfirst_q, idmode_q, cal_q;
  reg [CW-1:0] tmr_q;
  reg [15:0] w1_q, w2_q;
  // two-entry output buffer
  reg [7:0] buf_q [0:1];
  reg [1:0] bcnt_q;
  reg bwr_q, brd_q;
  reg [2:0] fill_q;
  wire buf_in_ready = (bcnt_q != 2'd2);
  wire buf_out_valid = (bcnt_q != 2'd0);
  wire [2:0] nbytes = idmode_q ? 3'd3 : 3'd6;
  reg [7:0] fill_byte;
  reg buf_pop;

  always @*
  begin
    case (fill_q)
      3'd0: fill_byte = w1_q[15:8];
      3'd1: fill_byte = w1_q[7:0];
      3'd2: fill_byte = crc16(w1_q);
      3'd3: fill_byte = w2_q[15:8];
      3'd4: fill_byte = w2_q[7:0];
      default: fill_byte = crc16(w2_q);
    endcase
  end
  wire fill_valid = rd_q && (fill_q < nbytes) && (cs_q != C_MEAS);
  wire buf_push = fill_valid & buf_in_ready;

  // buffer fill and drain
  always @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      bcnt_q <= 2'd0;
      bwr_q <= 1'b0;
      brd_q <= 1'b0;
      fill_q <= 3'd0;
      buf_q[0] <= 8'h00;
      buf_q[1] <= 8'h00;
    end
    else if (clk_en)
    begin
      if (!rd_q)
      begin
        // pointers realigned too, a cut read must not skew the next one
        bcnt_q <= 2'd0;
        fill_q <= 3'd0;
        bwr_q <= 1'b0;
        brd_q <= 1'b0;
      end
      else
      begin
        if (buf_push)
        begin
          buf_q[bwr_q] <= fill_byte;
          bwr_q <= ~bwr_q;
          fill_q <= fill_q + 3'd1;
        end
        if (buf_pop)
          brd_q <= ~brd_q;
        bcnt_q <= bcnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
      end
    end

  // bus engine and measurement core
  always @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      bs_q <= S_IDLE;
      cs_q <= C_PU;
      bit_q <= 4'd0;
      sh_q <= 8'h00;
      bidx_q <= 3'd0;
      hdr_q <= 1'b0;
      rd_q <= 1'b0;
      mine_q <= 1'b0;
      ack_q <= 1'b0;
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
      cmd_hi_q <= 8'h00;
      stretch_q <= 1'b0;
      hfirst_q <= 1'b0;
      idmode_q <= 1'b0;
      cal_q <= 1'b1;
      tmr_q <= PU_CYC[CW-1:0];
      w1_q <= 16'h0000;
      w2_q <= 16'h0000;
      buf_pop <= 1'b0;
    end
    else if (clk_en)
    begin
      buf_pop <= 1'b0;
      if (cs_q == C_PU || cs_q == C_MEAS)
      begin
        if (tmr_q <= 1)
        begin
          cal_q <= 1'b0;
          if (cs_q == C_PU)
            cs_q <= C_IDLE;
          else
          begin
            cs_q <= C_DONE;
            w1_q <= hfirst_q ? raw_humidity_word : raw_temperature_word;
            w2_q <= hfirst_q ? raw_temperature_word : raw_humidity_word;
          end
        end
        else
          tmr_q <= tmr_q - 1'b1;
      end
      if (start_c)
      begin
        bs_q <= S_RX;
        bit_q <= 4'd0;
        hdr_q <= 1'b1;
        rd_q <= 1'b0;
        sda_low_q <= 1'b0;
      end
      else if (stop_c)
      begin
        bs_q <= S_IDLE;
        rd_q <= 1'b0;
        sda_low_q <= 1'b0;
      end
      else
        case (bs_q)
          S_RX:
            if (scl_r)
            begin
              sh_q <= {sh_q[6:0], sda_q};
              bit_q <= bit_q + 4'd1;
            end
            else if (scl_f && bit_q == 4'd8)
            begin
              bs_q <= S_RXACK;
              ack_q <= 1'b0;
              if (hdr_q)
              begin
                mine_q <= (sh_q[7:1] == `HTI_ADDR) && cs_q != C_PU &&
                  !(cs_q == C_MEAS && (!stretch_q || !sh_q[0]));
                ack_q <= (sh_q[7:1] == `HTI_ADDR) && cs_q != C_PU &&
                  !(cs_q == C_MEAS && (!stretch_q || !sh_q[0]));
                bidx_q <= 3'd0;
              end
              else
                ack_q <= mine_q;
              sda_low_q <= hdr_q ? ((sh_q[7:1] == `HTI_ADDR) &&
                cs_q != C_PU && !(cs_q == C_MEAS &&
                (!stretch_q || !sh_q[0]))) : mine_q;
            end
          S_RXACK:
            if (scl_f)
            begin
              sda_low_q <= 1'b0;
              bit_q <= 4'd0;
              if (!ack_q)
                bs_q <= S_IDLE;
              else if (hdr_q)
              begin
                hdr_q <= 1'b0;
                if (sh_q[0])
                begin
                  rd_q <= 1'b1;
                  bs_q <= (cs_q == C_MEAS) ? S_STRETCH : S_TX;
                  scl_low_q <= 1'b1;
                end
                else
                  bs_q <= S_RX;
              end
              else if (bidx_q == 3'd0)
              begin
                cmd_hi_q <= sh_q;
                bidx_q <= 3'd1;
                bs_q <= S_RX;
              end
              else
              begin
                bs_q <= S_RX;
                bidx_q <= 3'd0;
                case ({cmd_hi_q, sh_q})
                  `HTI_CMD_MT_S, `HTI_CMD_MH_S,
                  `HTI_CMD_MT_N, `HTI_CMD_MH_N:
                  begin
                    cs_q <= C_MEAS;
                    tmr_q <= MEAS_CYC[CW-1:0];
                    idmode_q <= 1'b0;
                    stretch_q <= ({cmd_hi_q, sh_q} == `HTI_CMD_MT_S) ||
                      ({cmd_hi_q, sh_q} == `HTI_CMD_MH_S);
                    hfirst_q <= ({cmd_hi_q, sh_q} == `HTI_CMD_MH_S) ||
                      ({cmd_hi_q, sh_q} == `HTI_CMD_MH_N);
                  end
                  `HTI_CMD_RST:
                  begin
                    cs_q <= C_PU;
                    tmr_q <= SR_CYC[CW-1:0];
                    cal_q <= 1'b1;
                    idmode_q <= 1'b0;
                    stretch_q <= 1'b0;
                    bs_q <= S_IDLE;
                  end
                  `HTI_CMD_ID:
                  begin
                    idmode_q <= 1'b1;
                    w1_q <= {ID_UPPER, `HTI_PROD_CODE};
                    cs_q <= C_DONE;
                  end
                  default:
                    cs_q <= cs_q;
                endcase
              end
            end
          S_STRETCH:
            if (cs_q != C_MEAS && buf_out_valid)
              bs_q <= S_TX;
          S_TX:
            if (bit_q == 4'd0 && buf_out_valid && scl_low_q)
            begin
              sh_q <= buf_q[brd_q];
              buf_pop <= 1'b1;
              sda_low_q <= ~buf_q[brd_q][7];
              scl_low_q <= 1'b0;
              bit_q <= 4'd1;
            end
            else if (bit_q == 4'd0 && !scl_q && !buf_out_valid)
              scl_low_q <= 1'b1;
            else if (scl_f && bit_q != 4'd0)
            begin
              if (bit_q == 4'd8)
              begin
                sda_low_q <= 1'b0;
                bs_q <= S_TXACK;
              end
              else
              begin
                sh_q <= {sh_q[6:0], 1'b0};
                sda_low_q <= ~sh_q[6];
                bit_q <= bit_q + 4'd1;
              end
            end
          S_TXACK:
            if (scl_r && sda_q)
              bs_q <= S_IDLE;
            else if (scl_f)
            begin
              // ack seen: next byte starts only once the ack clock ends
              bit_q <= 4'd0;
              scl_low_q <= 1'b1;
              bs_q <= buf_out_valid ? S_TX : S_IDLE;
            end
          default:
            bs_q <= S_IDLE;
        endcase
      if (bs_q == S_IDLE || start_c || stop_c)
        scl_low_q <= 1'b0;
    end

  assign sda_out = 1'b0;
  assign sda_oe = sda_low_q;
  assign scl_out = 1'b0;
  assign scl_oe = scl_low_q && (bs_q == S_STRETCH || bs_q == S_TX);
  assign idle = (cs_q != C_PU) && (cs_q != C_MEAS) && (bs_q == S_IDLE);
  assign measuring = (cs_q == C_MEAS);
  assign calib_reload = cal_q;
endmodule
`default_nettype wire

// ---- testbench/hti_sensor_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module hti_sensor_props #(
  parameter PU_CYC = 50,
  parameter SR_CYC = 50,
  parameter MEAS_CYC = 400
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic idle,
  input wire logic measuring,
  input wire logic calib_reload
);
  localparam int LO = (PU_CYC < SR_CYC ? PU_CYC : SR_CYC) - 2;
  localparam int HI = (PU_CYC > SR_CYC ? PU_CYC : SR_CYC) + 3;
  logic [31:0] rl_q;
  logic [31:0] ms_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // length of reload and conversion, too long to unroll
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rl_q <= '0;
      ms_q <= '0;
    end
    else
    begin
      rl_q <= calib_reload ? rl_q + 1 : '0;
      ms_q <= measuring ? ms_q + 1 : '0;
    end
  end
  property p_sda_low; sda_oe |-> !sda_out; endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda high");
  property p_scl_low; scl_oe |-> !scl_out; endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl high");
  // outside a conversion only a brief hold while a byte is loaded
  property p_st_cause; $rose(scl_oe) && !measuring |-> ##[1:4] !scl_oe;
  endproperty
  a_st_cause: assert property (p_st_cause) else $error("stretch");
  property p_st_end; $fell(measuring) |-> ##[0:3] !scl_oe; endproperty
  a_st_end: assert property (p_st_end) else $error("stretch end");
  property p_rl_len; $fell(calib_reload) |-> rl_q >= LO && rl_q <= HI;
  endproperty
  a_rl_len: assert property (p_rl_len) else $error("reload len");
  property p_ms_len; measuring |-> ms_q <= MEAS_CYC + 2; endproperty
  a_ms_len: assert property (p_ms_len) else $error("meas len");
  property p_busy; measuring || calib_reload |-> !idle; endproperty
  a_busy: assert property (p_busy) else $error("idle busy");
  property p_rl_quiet; calib_reload |-> !measuring && !sda_oe; endproperty
  a_rl_quiet: assert property (p_rl_quiet) else $error("reload");
  property p_ms_go; $rose(measuring) |-> sda_oe || $past(sda_oe); endproperty
  a_ms_go: assert property (p_ms_go) else $error("meas start");
  property p_idle; $fell(calib_reload) |-> ##[0:3] idle; endproperty
  a_idle: assert property (p_idle) else $error("no idle");
endmodule
bind hti_sensor hti_sensor_props #(.PU_CYC(PU_CYC), .SR_CYC(SR_CYC),
  .MEAS_CYC(MEAS_CYC)) u_hti_sensor_props (.clk_sys(clk_sys),
  .reset(reset), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
  .sda_oe(sda_oe), .idle(idle), .measuring(measuring),
  .calib_reload(calib_reload));
`default_nettype wire

// ---- testbench/hti_mst.sv ----
`timescale 1ns/1ps
`default_nettype none
module hti_mst (
  input wire logic clk_sys,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  initial scl_pull = 1'b0;
  initial sda_pull = 1'b0;
  // quarter of a 400 ns bus period
  task automatic q;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic start;
    sda_pull = 1'b0;
    q;
    q;
    scl_pull = 1'b0;
    q;
    sda_pull = 1'b1;
    q;
    scl_pull = 1'b1;
    q;
  endtask
  task automatic stop;
    sda_pull = 1'b1;
    q;
    scl_pull = 1'b0;
    q;
    sda_pull = 1'b0;
    q;
  endtask
  task automatic bit_io(input logic b, output logic s);
    int n;
    sda_pull = !b;
    q;
    scl_pull = 1'b0;
    for (n = 0; n < 5000 && !scl; n++) @(posedge clk_sys);
    q;
    s = sda;
    q;
    scl_pull = 1'b1;
    q;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a,
    output logic [7:0] r, output logic s);
    int i;
    for (i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, s);
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hti_defs.vh"
module tb;
  localparam int PU = 200;
  localparam int SR = 150;
  localparam int MC = 600;
  localparam logic [9:0] IDU = 10'h2A5;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] raw_h = 16'hA7F1;
  logic [15:0] raw_t = 16'h63C4;
  wire scl_oe, sda_oe, scl_out, sda_out, idle, measuring, calib_reload;
  wire scl_m, sda_m, scl, sda;
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] b0, b1, b2;
  logic a0, a1, a2;
  // open-drain wires with pull-ups
  assign scl = !(scl_m | scl_oe);
  assign sda = !(sda_m | sda_oe);
  hti_sensor #(.PU_CYC(PU), .SR_CYC(SR), .MEAS_CYC(MC), .ID_UPPER(IDU))
    u_hti_sensor (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .raw_humidity_word(raw_h),
    .raw_temperature_word(raw_t), .idle(idle), .measuring(measuring),
    .calib_reload(calib_reload));
  hti_mst u_hti_mst (.clk_sys(clk_sys), .scl(scl), .sda(sda),
    .scl_pull(scl_m), .sda_pull(sda_m));
  initial forever #25 clk_sys = !clk_sys;
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    int i;
    c = 8'hFF;
    for (i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hdr(input logic rd);
    u_hti_mst.start;
    u_hti_mst.xfer({`HTI_ADDR, rd}, 1'b1, b0, a0);
  endtask
  task automatic cmd(input logic [15:0] c);
    hdr(1'b0);
    u_hti_mst.xfer(c[15:8], 1'b1, b0, a1);
    u_hti_mst.xfer(c[7:0], 1'b1, b0, a2);
  endtask
  task automatic rd3(input logic [15:0] w, input logic last);
    u_hti_mst.xfer(8'hFF, 1'b0, b0, a1);
    u_hti_mst.xfer(8'hFF, 1'b0, b1, a1);
    u_hti_mst.xfer(8'hFF, last, b2, a1);
    chk({b0, b1, b2}, {w, crc8(w)});
  endtask
  task automatic wait_idle(input int lim);
    int n;
    for (n = 0; n < lim && idle !== 1'b1; n++) @(posedge clk_sys);
    chk(idle, 1'b1);
  endtask
  task automatic t_id;
    hdr(1'b0);
    u_hti_mst.stop;
    chk(a0, 1'b1);
    wait_idle(PU);
    u_hti_mst.start;
    u_hti_mst.xfer(8'hE2, 1'b1, b0, a0);
    chk(a0, 1'b1);
    cmd(`HTI_CMD_ID);
    chk({a0, a1, a2}, 3'b000);
    hdr(1'b1);
    chk(a0, 1'b0);
    rd3({IDU, `HTI_PROD_CODE}, 1'b1);
    u_hti_mst.stop;
  endtask
  task automatic t_meas(input logic [15:0] c, input logic tf, input logic st);
    int n;
    cmd(c);
    // the ack clock fall reaches the core three clocks later
    repeat (2) @(posedge clk_sys);
    #1;
    chk(measuring, 1'b1);
    hdr(1'b1);
    chk(a0, !st);
    if (!st)
    begin
      u_hti_mst.stop;
      for (n = 0; n < MC && measuring; n++) @(posedge clk_sys);
      hdr(1'b1);
    end
    rd3(tf ? raw_t : raw_h, 1'b0);
    rd3(tf ? raw_h : raw_t, 1'b1);
    u_hti_mst.stop;
  endtask
  task automatic t_nack;
    hdr(1'b1);
    u_hti_mst.xfer(8'hFF, 1'b0, b0, a1);
    u_hti_mst.xfer(8'hFF, 1'b1, b1, a1);
    u_hti_mst.xfer(8'hFF, 1'b1, b2, a1);
    chk({a0, b0, b1, b2}, {1'b0, raw_h, 8'hFF});
    u_hti_mst.stop;
  endtask
  task automatic t_reset;
    cmd(`HTI_CMD_RST);
    u_hti_mst.stop;
    chk({a0, a1, a2, calib_reload}, 4'b0001);
    hdr(1'b1);
    u_hti_mst.stop;
    chk(a0, 1'b1);
    wait_idle(SR);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    t_id;
    t_meas(`HTI_CMD_MT_S, 1'b1, 1'b1);
    t_meas(`HTI_CMD_MH_S, 1'b0, 1'b1);
    t_meas(`HTI_CMD_MT_N, 1'b1, 1'b0);
    t_meas(`HTI_CMD_MH_N, 1'b0, 1'b0);
    t_nack;
    t_reset;
    final_report;
  end
  // watchdog well past the expected run
  initial
  begin
    #2000000;
    mismatches++;
    final_report;
  end
endmodule
`default_nettype wire
